// ---- bench/sync_peer.sv ----
// Purpose: Far-side serial peer, clock source in slave mode, data source and sink.
// Assumes: Line levels are resolved in the bench.
// Notes: Past the loaded bits the data line toggles so stale bits never pass as good.
`timescale 1ns/100ps
module sync_peer (
  input wire logic line_ck,
  input wire logic line_dt,
  input wire logic dev_dt_oe,
  output logic peer_ck,
  output logic peer_dt
);
  logic [31:0] stream;
  int idx;
  int len;
  logic [8:0] cap;
  initial begin
    peer_ck = 1'b0;
    peer_dt = 1'b0;
    idx = 0;
    len = 0;
    cap = 9'h000;
  end
  task load(input logic [31:0] s, input int n);
    stream = s;
    len = n;
    idx = 0;
  endtask
  // The clock stands low between frames.
  task pulses(input int n);
    repeat (n) begin
      #80 peer_ck = 1'b1;
      #80 peer_ck = 1'b0;
    end
  endtask
  // New data goes out on the rising edge so it is settled at the sampling fall.
  always @(posedge line_ck) begin
    if (idx < len) begin
      peer_dt <= stream[idx];
      idx <= idx + 1;
    end else begin
      peer_dt <= ~peer_dt;
    end
  end
  always @(negedge line_ck) if (dev_dt_oe) cap <= {line_dt, cap[8:1]};
endmodule

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the sync serial port.
// Assumes: Register port, read data one cycle after the strobe.
// Notes: Baud divisor 3 gives a master half period of 4 cycles.
`timescale 1ns/100ps
module tb;
  import usart_sync_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  addr_t reg_addr = 3'h0;
  byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sleep_mode = 1'b0;
  byte_t reg_rdata;
  logic ck_out, ck_oe, dt_out, dt_oe, peer_ck, peer_dt;
  logic rx_irq, tx_irq, rx_irq_high, tx_irq_high, wake;
  wire logic ck_line = ck_oe ? ck_out : peer_ck;
  wire logic dt_line = dt_oe ? dt_out : peer_dt;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  byte_t d;
  byte_t rst_tab [8] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  always #2.5 core_clk = ~core_clk;
  usart_sync i_usart_sync (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_mode(sleep_mode), .shift_clock_line_in(ck_line), .shift_clock_line_out(ck_out),
    .shift_clock_line_oe(ck_oe), .serial_data_line_in(dt_line), .serial_data_line_out(dt_out),
    .serial_data_line_oe(dt_oe), .rx_irq(rx_irq), .tx_irq(tx_irq),
    .rx_irq_high(rx_irq_high), .tx_irq_high(tx_irq_high), .wake(wake));
  sync_peer i_sync_peer (.line_ck(ck_line), .line_dt(dt_line), .dev_dt_oe(dt_oe),
    .peer_ck(peer_ck), .peer_dt(peer_dt));
  task final_report;
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task cmp(input string nm, input logic [8:0] exp, input logic [8:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      failures++;
    end
  endtask
  task wr(input addr_t a, input byte_t v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input addr_t a, output byte_t v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task chk(input addr_t a, input byte_t m, input byte_t exp);
    rd(a, d);
    cmp($sformatf("reg %0d", a), {1'b0, exp}, {1'b0, d & m});
  endtask
  task automatic wait_for(input bit on_wake, input string nm);
    int n;
    n = 0;
    while ((on_wake ? wake : rx_irq) !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    cmp(nm, 9'h001, {8'h00, on_wake ? wake : rx_irq});
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      final_report;
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) chk(addr_t'(i), 8'hff, rst_tab[i]);
    wr(3'h4, 8'hff);
    chk(3'h4, 8'hff, 8'h00);
    wr(3'h2, 8'h30);
    chk(3'h2, 8'hff, 8'h30);
    cmp("irq_high", 9'h003, {7'h00, rx_irq_high, tx_irq_high});
    wr(3'h6, 8'h03);
    chk(3'h6, 8'hff, 8'h03);
    wr(3'h5, 8'h90);
    wr(3'h1, 8'h20);
    wr(3'h3, 8'h80);
    i_sync_peer.load(32'h0000_00a5, 8);
    wr(3'h3, 8'ha0);
    wait_for(1'b0, "rx_irq");
    chk(3'h3, 8'hff, 8'h80);
    chk(3'h4, 8'hff, 8'ha5);
    cmp("rx_irq", 9'h000, {8'h00, rx_irq});
    cmp("ck_oe", 9'h000, {8'h00, ck_oe});
    i_sync_peer.load({5'h00, 9'h055, 9'h0c3, 9'h13c}, 27);
    wr(3'h3, 8'hf0);
    wait_for(1'b0, "rx_irq");
    chk(3'h3, 8'h01, 8'h01);
    chk(3'h4, 8'hff, 8'h3c);
    for (int n = 0; n < 200 && d[1] !== 1'b1; n++) rd(3'h3, d);
    chk(3'h3, 8'h03, 8'h02);
    chk(3'h4, 8'hff, 8'hc3);
    wr(3'h3, 8'hc0);
    chk(3'h3, 8'hff, 8'hc0);
    wr(3'h3, 8'h80);
    wr(3'h5, 8'h30);
    wr(3'h1, 8'h10);
    wr(3'h7, 8'h5a);
    repeat (2) @(posedge core_clk);
    wr(3'h7, 8'h96);
    sleep_mode <= 1'b1;
    chk(3'h0, 8'h10, 8'h00);
    chk(3'h5, 8'h02, 8'h00);
    cmp("wake", 9'h000, {8'h00, wake});
    i_sync_peer.pulses(8);
    wait_for(1'b1, "wake");
    cmp("tx word 1", 9'h05a, {1'b0, i_sync_peer.cap[8:1]});
    wr(3'h0, 8'h00);
    chk(3'h0, 8'h10, 8'h10);
    i_sync_peer.pulses(8);
    // The last pin fall needs a few core cycles to pass the synchroniser.
    repeat (8) @(posedge core_clk);
    cmp("tx word 2", 9'h096, {1'b0, i_sync_peer.cap[8:1]});
    chk(3'h5, 8'h02, 8'h02);
    sleep_mode <= 1'b0;
    wr(3'h5, 8'h10);
    wr(3'h1, 8'h20);
    wr(3'h3, 8'ha0);
    i_sync_peer.load(32'h0000_003c, 8);
    i_sync_peer.pulses(8);
    repeat (8) @(posedge core_clk);
    chk(3'h0, 8'h20, 8'h00);
    wr(3'h3, 8'h90);
    sleep_mode <= 1'b1;
    i_sync_peer.load(32'h0000_00c6, 8);
    i_sync_peer.pulses(8);
    wait_for(1'b1, "wake");
    // A quiet pin lets the checker hold the buffer read to clearing the flag.
    repeat (16) @(posedge core_clk);
    chk(3'h3, 8'h02, 8'h00);
    chk(3'h4, 8'hff, 8'hc6);
    cmp("rx_irq", 9'h000, {8'h00, rx_irq});
    final_report;
  end
endmodule

// ---- bench/usart_sync_chk.sv ----
// Purpose: Port-level checks on the sync serial port.
// Assumes: Sees only the top module ports.
// Notes: Bound to every usart_sync instance.
`timescale 1ns/100ps
module usart_sync_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire usart_sync_pkg::addr_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire usart_sync_pkg::byte_t reg_rdata,
  input wire logic sleep_mode,
  input wire logic shift_clock_line_in,
  input wire logic shift_clock_line_out,
  input wire logic shift_clock_line_oe,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe,
  input wire logic rx_irq,
  input wire logic tx_irq,
  input wire logic rx_irq_high,
  input wire logic wake
);
  import usart_sync_pkg::*;
  logic [3:0] quiet;
  logic ck_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // A word can only finish shortly after a pin clock edge, so a quiet pin rules out set-wins.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quiet <= 4'h0;
      ck_q <= 1'b0;
    end else begin
      ck_q <= shift_clock_line_in;
      quiet <= (shift_clock_line_in != ck_q) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    end
  end
  property p_rdata; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");
  property p_wake; wake == (sleep_mode && (rx_irq || tx_irq)); endproperty
  a_wake: assert property (p_wake) else $error("wake mismatch");
  property p_txfall; $fell(tx_irq) |-> $past(reg_wr && reg_addr inside {3'h1, 3'h7}); endproperty
  a_txfall: assert property (p_txfall) else $error("transmit flag cleared without write");
  property p_ckidle; !shift_clock_line_oe |-> !shift_clock_line_out; endproperty
  a_ckidle: assert property (p_ckidle) else $error("clock level while undriven");
  property p_ckstart; $rose(shift_clock_line_oe) |-> !shift_clock_line_out ##1 !shift_clock_line_out; endproperty
  a_ckstart: assert property (p_ckstart) else $error("clock starts high");
  property p_rdclr;
    reg_rd && reg_addr == 3'h4 && !shift_clock_line_oe && quiet == 4'hf |=> !rx_irq;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("receive flag kept after read");
  property p_dtchg;
    serial_data_line_oe && $past(serial_data_line_oe) && $changed(serial_data_line_out)
      |-> !shift_clock_line_in;
  endproperty
  a_dtchg: assert property (p_dtchg) else $error("data changed while clock high");
  property p_prio; $changed(rx_irq_high) |-> $past(reg_wr && reg_addr == 3'h2); endproperty
  a_prio: assert property (p_prio) else $error("priority changed without write");
endmodule
bind usart_sync usart_sync_chk i_chk (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
  .shift_clock_line_in(shift_clock_line_in), .shift_clock_line_out(shift_clock_line_out),
  .shift_clock_line_oe(shift_clock_line_oe), .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe(serial_data_line_oe), .rx_irq(rx_irq), .tx_irq(tx_irq),
  .rx_irq_high(rx_irq_high), .wake(wake));

// ---- rtl/usart_sync.sv ----
// Purpose: Clocked half-duplex serial port, master receive and slave transmit/receive.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: Link pins are sampled by core_clk through two flip-flops.
// Notes on behaviour
// R01: Reception starts when single-word or continuous receive enable is set.
// R02: The data line is sampled on each falling shift clock edge.
// R03: Single-word enable alone receives one word, then reception stops.
// R04: Continuous enable keeps receiving words until software clears it.
// R05: With both enables set, continuous reception applies.
// R06: A finished word sets the receive-done flag; enabled, it requests interrupt.
// R07: Ninth bit and errors in receive status, word in receive buffer.
// R08: Clearing continuous enable clears receive errors; software does so after errors.
// R09: Nine-bit select receives 9-bit words with the extra bit kept.
// R10: Software loads divisor and sets mode, port and clock source first.
// R11: Software clears both enables, then sets exactly one for master reception.
// R12: Clock source clear takes the shift clock from the pin, peer drives it.
// R13: Slave mode keeps shifting during sleep because the clock is external.
// R14: Slave transfers behave like master ones except sleep and single-word enable.
// R15: Two buffered words: first loads shifter at once, flag stays clear.
// R16: After the first word shifts out, second loads, then flag sets.
// R17: Transmit buffer empty with its enable set wakes the core.
// R18: Slave reception ignores the single-word enable.
// R19: Continuous slave reception completes a word in sleep and wakes the core.
// R20: Slave transmit: software clears receive enables, sets transmit, writes buffer.
// R21: Mode bit plus port enable turn the pins into clock and data.
// R22: Transmit buffer empty flag clears only by writing the buffer.
// R23: Shifter-empty status is read-only and set while the shifter is empty.
// R24: Master drives the shift clock at divisor rate only while shifting.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "usart_sync_regs.svh"

module usart_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire usart_sync_pkg::addr_t reg_addr,
  input wire usart_sync_pkg::byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output usart_sync_pkg::byte_t reg_rdata,
  input wire logic sleep_mode,
  input wire logic shift_clock_line_in,
  output logic shift_clock_line_out,
  output logic shift_clock_line_oe,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output logic rx_irq,
  output logic tx_irq,
  output logic rx_irq_high,
  output logic tx_irq_high,
  output logic wake
);
  import usart_sync_pkg::*;

  state_t s;
  state_t next_s;

  function automatic logic [3:0] word_bits(input logic nine);
    word_bits = nine ? `NINE_MODE_BITS : `SYNC_MODE_BITS;
  endfunction

  logic mode_on;
  logic master;
  logic rx_req;
  logic rx_on;
  logic tx_busy;
  logic run;
  logic tick;
  logic fall;
  logic rx_last;
  logic tx_flag;

  always_comb begin
    next_s = s;
    next_s.ck_s1 = shift_clock_line_in;
    next_s.ck_s2 = s.ck_s1;
    next_s.ck_prev = s.ck_s2;
    next_s.dt_s1 = serial_data_line_in;
    next_s.dt_s2 = s.dt_s1;
    next_s.rd_data = `RST_BYTE;

    mode_on = s.serial_port_enable & s.sync_mode; // R21
    master = mode_on & s.clock_source_select; // R12
    // In slave mode the single-word enable has no effect.
    rx_req = s.continuous_rx_enable | (s.single_word_rx_enable & master); // R01 R05 R18 R14
    rx_on = mode_on & rx_req; // R01
    tx_busy = (s.tx_state == TX_SHIFT);
    tx_flag = ~s.tx_full; // R22

    // The master clock halts in sleep; a slave follows the pin and keeps going.
    run = master & (rx_on | tx_busy) & ~sleep_mode; // R24 R13
    tick = run & (s.baud_cnt == 8'h00);
    if (run) begin
      if (tick) begin
        next_s.baud_cnt = s.baud_divisor; // R24
        next_s.sck = ~s.sck;
      end else begin
        next_s.baud_cnt = s.baud_cnt - 8'h01;
      end
    end else begin
      next_s.baud_cnt = s.baud_divisor;
      next_s.sck = 1'b0;
    end

    if (master) begin
      fall = tick & s.sck;
    end else begin
      fall = mode_on & s.ck_prev & ~s.ck_s2; // R12 R13
    end

    // Register reads; the answer stands in the next cycle only.
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_IRQ_FLAGS: begin
          next_s.rd_data[`BIT_RX_IRQ] = s.rx_done_flag;
          next_s.rd_data[`BIT_TX_IRQ] = tx_flag;
        end
        `OFS_IRQ_ENABLES: begin
          next_s.rd_data[`BIT_RX_IRQ] = s.rx_irq_enable;
          next_s.rd_data[`BIT_TX_IRQ] = s.tx_irq_enable;
        end
        `OFS_IRQ_PRIORITY: begin
          next_s.rd_data[`BIT_RX_IRQ] = s.rx_irq_priority;
          next_s.rd_data[`BIT_TX_IRQ] = s.tx_irq_priority;
        end
        `OFS_RX_STATUS: begin
          next_s.rd_data[`BIT_PORT_EN] = s.serial_port_enable;
          next_s.rd_data[`BIT_RX_NINE] = s.nine_bit_rx_select;
          next_s.rd_data[`BIT_SINGLE_RX] = s.single_word_rx_enable;
          next_s.rd_data[`BIT_CONT_RX] = s.continuous_rx_enable;
          next_s.rd_data[`BIT_ADDR_DET] = s.address_detect_enable;
          next_s.rd_data[`BIT_OVERRUN] = s.overrun_error; // R07
          next_s.rd_data[`BIT_RX_NINTH] = s.rx_ninth_bit; // R07
        end
        `OFS_RX_BUFFER: begin
          next_s.rd_data = s.receive_buffer; // R07
          next_s.rx_done_flag = 1'b0;
        end
        `OFS_TX_STATUS: begin
          next_s.rd_data[`BIT_CLK_SRC] = s.clock_source_select;
          next_s.rd_data[`BIT_TX_NINE] = s.nine_bit_tx_select;
          next_s.rd_data[`BIT_TX_EN] = s.transmit_enable;
          next_s.rd_data[`BIT_SYNC_MODE] = s.sync_mode;
          next_s.rd_data[`BIT_HIGH_BAUD] = s.high_baud_select;
          next_s.rd_data[`BIT_SHIFT_EMPTY] = ~tx_busy; // R23
          next_s.rd_data[`BIT_TX_NINTH] = s.tx_ninth_bit;
        end
        `OFS_BAUD_DIVISOR: begin
          next_s.rd_data = s.baud_divisor;
        end
        `OFS_TX_BUFFER: begin
          next_s.rd_data = s.transmit_buffer;
        end
      endcase
    end

    // Control writes; flag bits that hardware owns ignore writes.
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_IRQ_FLAGS: begin
        end
        `OFS_IRQ_ENABLES: begin
          next_s.rx_irq_enable = reg_wdata[`BIT_RX_IRQ];
          next_s.tx_irq_enable = reg_wdata[`BIT_TX_IRQ];
        end
        `OFS_IRQ_PRIORITY: begin
          next_s.rx_irq_priority = reg_wdata[`BIT_RX_IRQ];
          next_s.tx_irq_priority = reg_wdata[`BIT_TX_IRQ];
        end
        `OFS_RX_STATUS: begin
          next_s.serial_port_enable = reg_wdata[`BIT_PORT_EN];
          next_s.nine_bit_rx_select = reg_wdata[`BIT_RX_NINE];
          next_s.single_word_rx_enable = reg_wdata[`BIT_SINGLE_RX];
          next_s.continuous_rx_enable = reg_wdata[`BIT_CONT_RX];
          next_s.address_detect_enable = reg_wdata[`BIT_ADDR_DET];
          if (!reg_wdata[`BIT_CONT_RX]) begin
            next_s.overrun_error = 1'b0; // R08
          end
        end
        `OFS_RX_BUFFER: begin
        end
        `OFS_TX_STATUS: begin
          next_s.clock_source_select = reg_wdata[`BIT_CLK_SRC];
          next_s.nine_bit_tx_select = reg_wdata[`BIT_TX_NINE];
          next_s.transmit_enable = reg_wdata[`BIT_TX_EN];
          next_s.sync_mode = reg_wdata[`BIT_SYNC_MODE];
          next_s.high_baud_select = reg_wdata[`BIT_HIGH_BAUD];
          next_s.tx_ninth_bit = reg_wdata[`BIT_TX_NINTH];
        end
        `OFS_BAUD_DIVISOR: begin
          next_s.baud_divisor = reg_wdata;
        end
        `OFS_TX_BUFFER: begin
        end
      endcase
    end

    // Transmit path. Reception has priority: a word starts only with rx_req clear, and rx_req takes the data line.
    unique case (s.tx_state)
      TX_IDLE: begin
        if (mode_on & s.transmit_enable & s.tx_full & ~rx_req) begin
          next_s.tx_shifter = {s.tx_ninth_bit, s.transmit_buffer}; // R15 R16
          next_s.tx_cnt = word_bits(s.nine_bit_tx_select);
          next_s.tx_full = 1'b0; // R16
          next_s.tx_state = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (fall) begin
          // The peer has sampled this bit; present the next one.
          next_s.tx_shifter = {1'b0, s.tx_shifter[8:1]};
          next_s.tx_cnt = s.tx_cnt - 4'h1;
          if (s.tx_cnt == 4'h1) begin
            next_s.tx_state = TX_IDLE; // R16 R23
          end
        end
      end
    endcase
    if (!mode_on || !s.transmit_enable) begin
      next_s.tx_state = TX_IDLE;
    end

    // A buffer write after the load above keeps the new word pending.
    if (reg_wr && reg_addr == `OFS_TX_BUFFER) begin
      next_s.transmit_buffer = reg_wdata;
      next_s.tx_full = 1'b1; // R22 R15
    end

    // Receive path, placed after the reads so a finishing word wins.
    rx_last = (s.rx_cnt + 4'h1) == word_bits(s.nine_bit_rx_select);
    if (!rx_on) begin
      next_s.rx_cnt = 4'h0;
    end else if (fall) begin
      next_s.rx_shifter = {s.dt_s2, s.rx_shifter[8:1]}; // R02
      if (rx_last) begin
        next_s.rx_cnt = 4'h0;
        if (s.rx_done_flag && next_s.rx_done_flag) begin
          // The unread word is kept and the new one is lost.
          next_s.overrun_error = 1'b1; // R07
        end else begin
          if (s.nine_bit_rx_select) begin
            next_s.receive_buffer = next_s.rx_shifter[7:0]; // R09
            next_s.rx_ninth_bit = next_s.rx_shifter[8]; // R09
          end else begin
            next_s.receive_buffer = next_s.rx_shifter[8:1]; // R07
          end
          next_s.rx_done_flag = 1'b1; // R06 R19
        end
        if (!s.continuous_rx_enable) begin
          next_s.single_word_rx_enable = 1'b0; // R03
        end
        // Continuous reception just carries on with the next word.
      end else begin
        next_s.rx_cnt = s.rx_cnt + 4'h1; // R04
      end
    end

    // Pin drivers are registered so the pins never glitch.
    next_s.sck = next_s.sck & run;
    next_s.ck_out = next_s.sck;
    next_s.ck_oe = master & (rx_on | tx_busy | next_s.tx_state == TX_SHIFT); // R24
    next_s.dt_out = next_s.tx_shifter[0];
    next_s.dt_oe = mode_on & s.transmit_enable & ~rx_req; // R21
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      // Every control byte resets to zero; shifter-empty and the transmit flag are derived, so read as one.
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rd_data;
  assign shift_clock_line_out = s.ck_out;
  assign shift_clock_line_oe = s.ck_oe;
  assign serial_data_line_out = s.dt_out;
  assign serial_data_line_oe = s.dt_oe;
  assign rx_irq = s.rx_done_flag & s.rx_irq_enable; // R06
  assign tx_irq = ~s.tx_full & s.tx_irq_enable; // R17
  assign rx_irq_high = s.rx_irq_priority;
  assign tx_irq_high = s.tx_irq_priority;
  assign wake = sleep_mode & (rx_irq | tx_irq); // R17 R19

endmodule

// ---- rtl/usart_sync_pkg.sv ----
// Purpose: Types shared by the sync serial port.
// Assumes: Constants live in usart_sync_regs.svh.
// Notes: The whole module state is one packed struct.
package usart_sync_pkg;

  typedef logic [2:0] addr_t;
  typedef logic [7:0] byte_t;

  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

  typedef struct packed {
    logic ck_s1;
    logic ck_s2;
    logic ck_prev;
    logic dt_s1;
    logic dt_s2;
    logic serial_port_enable;
    logic nine_bit_rx_select;
    logic single_word_rx_enable;
    logic continuous_rx_enable;
    logic address_detect_enable;
    logic overrun_error;
    logic rx_ninth_bit;
    logic clock_source_select;
    logic nine_bit_tx_select;
    logic transmit_enable;
    logic sync_mode;
    logic high_baud_select;
    logic tx_ninth_bit;
    byte_t baud_divisor;
    byte_t receive_buffer;
    byte_t transmit_buffer;
    logic tx_full;
    logic rx_done_flag;
    logic rx_irq_enable;
    logic tx_irq_enable;
    logic rx_irq_priority;
    logic tx_irq_priority;
    byte_t baud_cnt;
    logic sck;
    tx_state_t tx_state;
    logic [8:0] tx_shifter;
    logic [3:0] tx_cnt;
    logic [8:0] rx_shifter;
    logic [3:0] rx_cnt;
    logic ck_out;
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
    byte_t rd_data;
  } state_t;

endpackage

// ---- rtl/usart_sync_regs.svh ----
// Purpose: Register offsets, field positions and reset values of the sync serial port.
// Assumes: Byte-wide registers on a 3-bit register address.
// Notes: Offsets are local to this block.
`ifndef USART_SYNC_REGS_SVH
`define USART_SYNC_REGS_SVH

`define OFS_IRQ_FLAGS 3'h0
`define OFS_IRQ_ENABLES 3'h1
`define OFS_IRQ_PRIORITY 3'h2
`define OFS_RX_STATUS 3'h3
`define OFS_RX_BUFFER 3'h4
`define OFS_TX_STATUS 3'h5
`define OFS_BAUD_DIVISOR 3'h6
`define OFS_TX_BUFFER 3'h7

`define BIT_RX_IRQ 5
`define BIT_TX_IRQ 4

`define BIT_PORT_EN 7
`define BIT_RX_NINE 6
`define BIT_SINGLE_RX 5
`define BIT_CONT_RX 4
`define BIT_ADDR_DET 3
`define BIT_FRAME_ERR 2
`define BIT_OVERRUN 1
`define BIT_RX_NINTH 0

`define BIT_CLK_SRC 7
`define BIT_TX_NINE 6
`define BIT_TX_EN 5
`define BIT_SYNC_MODE 4
`define BIT_HIGH_BAUD 2
`define BIT_SHIFT_EMPTY 1
`define BIT_TX_NINTH 0

`define RST_IRQ_REGS 8'h00
`define RST_RX_STATUS 8'h00
`define RST_TX_STATUS 8'h02
`define RST_BYTE 8'h00

`define SYNC_MODE_BITS 4'h8
`define NINE_MODE_BITS 4'h9

`endif
